// ---- inc/dehsc_consts.vh ----
`ifndef DEHSC_CONSTS_VH
`define DEHSC_CONSTS_VH
// Register byte offsets
`define DEHSC_OFF_CTRL 8'h00
`define DEHSC_OFF_CAUSE 8'h04
`define DEHSC_OFF_MON 8'h08
// Register indices
`define DEHSC_IDX_NONE 2'd0
`define DEHSC_IDX_CTRL 2'd1
`define DEHSC_IDX_CAUSE 2'd2
`define DEHSC_IDX_MON 2'd3
// Halt control/status register fields
`define DEHSC_CTRL_DBGEN 0
`define DEHSC_CTRL_HALT 1
`define DEHSC_CTRL_STEP 2
`define DEHSC_CTRL_MASK 3
`define DEHSC_CTRL_SHALT 16
// Exception monitor control register fields
`define DEHSC_MON_CATCH_RST 0
`define DEHSC_MON_CATCH_HF 1
// Cause status register fields
`define DEHSC_CAUSE_W 5
`define DEHSC_CAUSE_HALTED 0
`define DEHSC_CAUSE_BREAKPOINT_CAUSE_FLAG 1
`define DEHSC_CAUSE_WATCH 2
`define DEHSC_CAUSE_CATCH 3
`define DEHSC_CAUSE_EXT 4
`define DEHSC_CAUSE_RESET 5'h00
// Bus constants
`define DEHSC_ZERO32 32'h0000_0000
`define DEHSC_HRESP_OKAY 1'b0
// Debug states, one-hot
`define DEHSC_ST_RUN 3'b001
`define DEHSC_ST_HALT 3'b010
`define DEHSC_ST_STEP 3'b100
`endif

// ---- verif/dehsc_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module dehsc_host_model (
  input wire logic mclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  // Idle bus at time zero
  initial begin
    hsel = 1'h0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
  end
  // One single word transfer; callers keep mask set and halt release apart
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    @(posedge mclk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    do @(posedge mclk); while (hready !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hready !== 1'h1);
    r = hrdata;
    hwdata <= ~d;
  endtask
endmodule
`default_nettype wire

// ---- verif/dehsc_top_properties.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "dehsc_consts.vh"
module dehsc_top_properties (
  input wire logic mclk,
  input wire logic rst,
  input wire logic localRst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic boundary,
  input wire logic bkptInstr,
  input wire logic fetchFault,
  input wire logic inNmiOrHardFault,
  input wire logic externalHaltRequest,
  input wire logic halted,
  input wire logic lockup,
  input wire logic hardFaultReq,
  input wire logic suppressSync,
  input wire logic blockPendSv,
  input wire logic blockSysTick,
  input wire logic blockExtIrq
);
  logic wrQ, enQ;
  logic [7:0] aQ;
  wire go = boundary && !halted && !lockup;
  wire ctl = wrQ && aQ == `DEHSC_OFF_CTRL;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Mirror of the debug enable bit, taken from bus writes
  always @(posedge mclk) begin
    wrQ <= !rst && hsel && htrans[1] && hwrite && hready;
    aQ <= haddr[7:0];
    if (rst) enQ <= 1'h0;
    else if (ctl) enQ <= hwdata[`DEHSC_CTRL_DBGEN];
  end
  property p_ext_halt; go && enQ && externalHaltRequest |=> halted; endproperty
  a_ext_halt: assert property (p_ext_halt) else $error("request did not halt");
  property p_hold; halted && enQ && !ctl && !localRst |=> halted; endproperty
  a_hold: assert property (p_hold) else $error("left halt without a write");
  property p_dis; go && !enQ && bkptInstr && !fetchFault && !inNmiOrHardFault |=> hardFaultReq && !halted; endproperty
  a_dis: assert property (p_dis) else $error("breakpoint not escalated");
  property p_lock; go && !enQ && bkptInstr && !fetchFault && inNmiOrHardFault |=> lockup && !hardFaultReq; endproperty
  a_lock: assert property (p_lock) else $error("no lockup");
  property p_fetch; go && !enQ && bkptInstr && fetchFault |=> !hardFaultReq && !$rose(lockup); endproperty
  a_fetch: assert property (p_fetch) else $error("fetch fault gave breakpoint");
  property p_sup; go && enQ && bkptInstr && !fetchFault |=> suppressSync && halted; endproperty
  a_sup: assert property (p_sup) else $error("breakpoint not taken alone");
  property p_resume; ctl && halted && enQ && hwdata[2:1] == 2'h0 |=> !halted; endproperty
  a_resume: assert property (p_resume) else $error("no resume");
  property p_stay; ctl && halted && hwdata[0] && hwdata[`DEHSC_CTRL_HALT] |=> halted; endproperty
  a_stay: assert property (p_stay) else $error("halt write released");
  property p_off; !enQ [*2] |-> !halted && !blockPendSv; endproperty
  a_off: assert property (p_off) else $error("control acted while disabled");
  property p_mask; blockPendSv || blockSysTick || blockExtIrq |-> blockPendSv && blockSysTick && blockExtIrq && enQ;
  endproperty
  a_mask: assert property (p_mask) else $error("mask outputs disagree");
  c_halt: cover property (go && enQ && externalHaltRequest);
  c_fault: cover property (hardFaultReq);
  c_lock: cover property ($rose(lockup));
endmodule
`default_nettype wire

// ---- verif/dehsc_top_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "dehsc_consts.vh"
`define CHK(n, e, v) begin samplesChecked++; if ((v) !== (e)) begin nErrors++; $display("wrong value %s exp %h seen %h", n, e, v); end end
module dehsc_top_tb;
  localparam logic [7:0] rCtl = `DEHSC_OFF_CTRL;
  localparam logic [7:0] rCau = `DEHSC_OFF_CAUSE;
  logic mclk, rst, localRst, boundary;
  logic [9:0] ev;
  logic [31:0] rv;
  int nErrors = 0, samplesChecked = 0, cyc = 0;
  wire hsel, hwrite, hready, hresp, halted, runEnable, hardFaultReq, lockup, suppressSync;
  wire blockPendSv, blockSysTick, blockExtIrq;
  wire [31:0] haddr, hwdata, hrdata;
  wire [1:0] htrans;
  wire [2:0] hsize;
  dehsc_top u_dehsc_top (.mclk, .rst, .localRst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout(hready), .hresp, .hrdata, .boundary, .externalHaltRequest(ev[0]), .bkptInstr(ev[1]),
    .bpuMatch(ev[2]), .dwtMatch(ev[3]), .coreResetExit(ev[4]), .hardFaultEntry(ev[5]), .fetchFault(ev[6]),
    .undefInstr(ev[7]), .dataMpuFault(ev[8]), .inNmiOrHardFault(ev[9]), .halted, .runEnable, .hardFaultReq,
    .lockup, .suppressSync, .blockPendSv, .blockSysTick, .blockExtIrq);
  dehsc_host_model u_dehsc_host_model (.mclk, .hready, .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata);
  // Clock and hang guard
  initial begin
    mclk = 1'h0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      nErrors++;
      closeOut();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_dehsc_host_model.xfer(a, 1'h1, d, rv);
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    u_dehsc_host_model.xfer(a, 1'h0, 32'h0000_0000, rv);
    #1;
  endtask
  // One instruction boundary with the given event levels
  task automatic bnd(input logic [9:0] e);
    @(posedge mclk);
    ev <= e;
    boundary <= 1'h1;
    @(posedge mclk);
    ev <= 10'h000;
    boundary <= 1'h0;
    #1;
  endtask
  task automatic tEvents;
    logic [9:0] evs [6] = '{10'h001, 10'h002, 10'h004, 10'h008, 10'h010, 10'h020};
    logic [31:0] cb [6] = '{32'h0000_0010, 32'h0000_0002, 32'h0000_0002, 32'h0000_0004, 32'h0000_0008, 32'h0000_0008};
    rd(rCau);
    `CHK("cause rst", 33'h0_0000_0000, {hresp, rv})
    wr(rCtl, 32'h0000_0001);
    wr(`DEHSC_OFF_MON, 32'h0000_0003);
    rd(`DEHSC_OFF_MON);
    `CHK("monitor", 32'h0000_0003, rv)
    for (int i = 0; i < 6; i++) begin
      bnd(evs[i]);
      `CHK("halted", 1'h1, halted)
      rd(rCtl);
      `CHK("ctrl", 32'h0001_0003, rv)
      bnd(10'h001);
      wr(rCau, 32'h0000_0000);
      rd(rCau);
      `CHK("cause", cb[i], rv)
      wr(rCau, 32'h0000_001F);
      rd(rCau);
      `CHK("cleared", 32'h0000_0000, rv)
      wr(rCtl, 32'h0000_0001);
      `CHK("resumed", 1'h0, halted)
    end
    $display("event test done");
  endtask
  task automatic tStep;
    wr(rCtl, 32'h0000_0003);
    bnd(10'h000);
    rd(rCau);
    `CHK("halt req", 32'h0000_0001, rv)
    wr(rCau, 32'h0000_001F);
    wr(rCtl, 32'h0000_0005);
    `CHK("step out", 1'h0, halted)
    bnd(10'h000);
    `CHK("stepped", 1'h0, halted)
    bnd(10'h020);
    `CHK("handler", 1'h1, halted)
    `CHK("suppress", 1'h1, suppressSync)
    rd(rCau);
    `CHK("step cause", 32'h0000_0001, rv)
    wr(rCtl, 32'h0000_0007);
    `CHK("kept", 1'h1, halted)
    $display("step test done");
  endtask
  task automatic tMask;
    wr(rCtl, 32'h0000_000B);
    `CHK("blocks", 3'h7, {blockPendSv, blockSysTick, blockExtIrq})
    wr(rCtl, 32'h0000_0009);
    `CHK("run mask", 4'h7, {halted, blockPendSv, blockSysTick, blockExtIrq})
    wr(rCtl, 32'h0000_000B);
    bnd(10'h000);
    wr(rCtl, 32'h0000_0003);
    `CHK("unmask", 4'h8, {halted, blockPendSv, blockSysTick, blockExtIrq})
    wr(rCtl, 32'h0000_0001);
    wr(rCau, 32'h0000_001F);
    bnd(10'h088);
    bnd(10'h108);
    `CHK("no watch", 1'h0, halted)
    rd(rCau);
    `CHK("watch flag", 32'h0000_0000, rv)
    $display("mask test done");
  endtask
  task automatic tOff;
    wr(rCtl, 32'h0000_0000);
    wr(rCtl, 32'h0000_000E);
    bnd(10'h00D);
    `CHK("ignored", 4'h0, {halted, blockPendSv, blockSysTick, blockExtIrq})
    bnd(10'h002);
    `CHK("hard fault", 1'h1, hardFaultReq)
    bnd(10'h042);
    `CHK("fetch", 1'h0, hardFaultReq)
    rd(rCau);
    `CHK("breakpoint_cause_flag flag", 32'h0000_0002, rv)
    bnd(10'h202);
    `CHK("lockup", 2'h2, {lockup, runEnable})
    @(posedge mclk) localRst <= 1'h1;
    @(posedge mclk) localRst <= 1'h0;
    rd(rCau);
    `CHK("local", 33'h1_0000_0002, {runEnable, rv})
    @(posedge mclk) rst <= 1'h1;
    @(posedge mclk) rst <= 1'h0;
    rd(rCau);
    `CHK("por", 32'h0000_0000, rv)
    $display("disabled test done");
  endtask
  task automatic closeOut;
    $display("checks %0d mismatches %0d", samplesChecked, nErrors);
    if (nErrors == 0 && samplesChecked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Reset, then the scenarios in order
  initial begin
    rst = 1'h1;
    localRst = 1'h0;
    boundary = 1'h0;
    ev = 10'h000;
    repeat (16) @(posedge mclk);
    rst <= 1'h0;
    tEvents();
    tStep();
    tMask();
    tOff();
    closeOut();
  end
endmodule
bind dehsc_top dehsc_top_properties u_dehsc_top_properties (.mclk, .rst, .localRst, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .boundary, .bkptInstr, .fetchFault, .inNmiOrHardFault, .externalHaltRequest, .halted, .lockup,
  .hardFaultReq, .suppressSync, .blockPendSv, .blockSysTick, .blockExtIrq);
`default_nettype wire

// ---- verilog/dehsc_cause_reg.v ----
`timescale 1ns/10ps
`default_nettype none
`include "dehsc_consts.vh"
module dehsc_cause_reg (
  input wire mclk,
  input wire rst,
  input wire [4:0] setBits,
  input wire clrWe,
  input wire [4:0] clrBits,
  output wire [4:0] causeBits
);
  reg [4:0] cause_q;
  wire [4:0] cause_d;

  // Sticky flags, write one to clear, a set in the same cycle wins
  assign cause_d = (cause_q & ~(clrWe ? clrBits : `DEHSC_CAUSE_RESET)) | setBits;

  // Only power-on reset clears the flags, local reset is not wired here
  always @(posedge mclk) begin
    if (rst) begin
      cause_q <= `DEHSC_CAUSE_RESET;
    end else begin
      cause_q <= cause_d;
    end
  end

  assign causeBits = cause_q;
endmodule
`default_nettype wire

// ---- verilog/dehsc_top.v ----
// Our own choices: the address map and register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "dehsc_consts.vh"
module dehsc_top (
  input wire mclk,
  input wire rst,
  input wire localRst,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output wire [31:0] hrdata,
  input wire boundary,
  input wire bkptInstr,
  input wire bpuMatch,
  input wire fetchFault,
  input wire undefInstr,
  input wire dataMpuFault,
  input wire dwtMatch,
  input wire coreResetExit,
  input wire hardFaultEntry,
  input wire inNmiOrHardFault,
  input wire externalHaltRequest,
  output wire halted,
  output wire runEnable,
  output wire hardFaultReq,
  output wire lockup,
  output wire suppressSync,
  output wire blockPendSv,
  output wire blockSysTick,
  output wire blockExtIrq
);
  // One-hot debug states
  localparam [2:0] ST_RUN = `DEHSC_ST_RUN;
  localparam [2:0] ST_HALT = `DEHSC_ST_HALT;
  localparam [2:0] ST_STEP = `DEHSC_ST_STEP;

  // Debug state
  reg [2:0] state_q;
  reg [2:0] state_d;
  // Control bits written by the debugger, kept through a local reset
  reg dbgEn_q;
  reg haltReq_q;
  reg stepReq_q;
  reg maskInts_q;
  reg catchRst_q;
  reg catchHf_q;
  // Step progress
  reg stepped_q;
  reg stepped_d;
  // Core-facing results
  reg lockup_q;
  reg hard_fault_exception_q;
  reg suppress_q;
  // Bus data phase tracking
  reg wrPend_q;
  reg [1:0] wrIdx_q;
  reg [31:0] rdata_q;
  // Boundary decision, built combinationally
  reg [4:0] causeSet;
  reg takeHalt;
  reg takeSync;
  reg raiseHf;
  reg raiseLock;
  // Register strobes and event candidates
  wire [4:0] causeBits;
  wire addrPhase;
  wire ctrlWr;
  wire monWr;
  wire causeClr;
  wire maskActive;
  wire bkptEvt;
  wire bpuEvt;
  wire catchEvt;
  wire watchEvt;
  wire stepEvt;
  wire haltEvt;
  wire extEvt;
  wire isHalted;

  // Map a byte address onto a register index
  // Only the low address byte is decoded
  function [1:0] regIndex;
    input [31:0] addr;
    begin
      case (addr[7:0])
        `DEHSC_OFF_CTRL: regIndex = `DEHSC_IDX_CTRL;
        `DEHSC_OFF_CAUSE: regIndex = `DEHSC_IDX_CAUSE;
        `DEHSC_OFF_MON: regIndex = `DEHSC_IDX_MON;
        default: regIndex = `DEHSC_IDX_NONE;
      endcase
    end
  endfunction

  // Data phase of a write to the given register
  function wrHit;
    input pend;
    input [1:0] idx;
    input [1:0] want;
    begin
      wrHit = pend & (idx == want);
    end
  endfunction

  // Zero-wait slave, always OKAY
  // Every transfer ends after one data phase, so no wait-state logic
  assign addrPhase = hsel & htrans[1] & hready;
  assign hreadyout = 1'b1;
  assign hresp = `DEHSC_HRESP_OKAY;
  assign hrdata = rdata_q;
  // Data phase write strobes, one per register
  assign ctrlWr = wrHit(wrPend_q, wrIdx_q, `DEHSC_IDX_CTRL);
  assign monWr = wrHit(wrPend_q, wrIdx_q, `DEHSC_IDX_MON);
  assign causeClr = wrHit(wrPend_q, wrIdx_q, `DEHSC_IDX_CAUSE);
  assign isHalted = state_q == ST_HALT;
  // Interrupt masking only counts while halting debug is on
  assign maskActive = dbgEn_q & maskInts_q;

  // Address phase capture and read data for the following data phase
  // Read data is loaded at the address edge so it stands all data phase
  // A read right behind a write to the same register sees the old value
  always @(posedge mclk) begin
    if (rst) begin
      wrPend_q <= 1'b0;
      wrIdx_q <= `DEHSC_IDX_NONE;
      rdata_q <= `DEHSC_ZERO32;
    end else begin
      wrPend_q <= addrPhase & hwrite;
      wrIdx_q <= regIndex(haddr);
      if (addrPhase & ~hwrite) begin
        // Unmapped offsets read as zero
        rdata_q <= `DEHSC_ZERO32;
        case (regIndex(haddr))
          `DEHSC_IDX_CTRL: begin
            rdata_q[`DEHSC_CTRL_DBGEN] <= dbgEn_q;
            rdata_q[`DEHSC_CTRL_HALT] <= haltReq_q;
            rdata_q[`DEHSC_CTRL_STEP] <= stepReq_q;
            rdata_q[`DEHSC_CTRL_MASK] <= maskInts_q;
            rdata_q[`DEHSC_CTRL_SHALT] <= isHalted;
          end
          `DEHSC_IDX_CAUSE: rdata_q[`DEHSC_CAUSE_W-1:0] <= causeBits;
          `DEHSC_IDX_MON: begin
            rdata_q[`DEHSC_MON_CATCH_RST] <= catchRst_q;
            rdata_q[`DEHSC_MON_CATCH_HF] <= catchHf_q;
          end
          default: rdata_q <= `DEHSC_ZERO32;
        endcase
      end
    end
  end

  // Candidate events presented by the core at an instruction boundary
  // A faulting fetch never yields a breakpoint; a data match is void when
  // the access cannot happen or already took a protection fault
  assign bkptEvt = bkptInstr & ~fetchFault;
  assign bpuEvt = bpuMatch & ~fetchFault;
  assign catchEvt = (catchRst_q & coreResetExit) | (catchHf_q & hardFaultEntry);
  assign watchEvt = dwtMatch & ~dataMpuFault & ~undefInstr;
  assign stepEvt = (state_q == ST_STEP) & stepped_q;
  assign haltEvt = haltReq_q & (state_q == ST_RUN);
  // External request is a level, dropped while halted
  assign extEvt = externalHaltRequest & ~isHalted;

  // Boundary decision: halt, escalate, or ignore
  always @* begin
    causeSet = `DEHSC_CAUSE_RESET;
    takeHalt = 1'b0;
    takeSync = 1'b0;
    raiseHf = 1'b0;
    raiseLock = 1'b0;
    // Nothing is taken while halted or locked; asynchronous requests wait
    // for the next boundary that the core reports
    if (boundary & ~isHalted & ~lockup_q) begin
      if (dbgEn_q) begin
        takeHalt = 1'b1;
        // One synchronous event wins, step first
        // Only the winner's cause flag is set
        if (stepEvt) begin
          causeSet[`DEHSC_CAUSE_HALTED] = 1'b1;
          takeSync = 1'b1;
        end else if (bkptEvt | bpuEvt) begin
          causeSet[`DEHSC_CAUSE_BREAKPOINT_CAUSE_FLAG] = 1'b1;
          takeSync = 1'b1;
        end else if (catchEvt) begin
          causeSet[`DEHSC_CAUSE_CATCH] = 1'b1;
          takeSync = 1'b1;
        end else if (haltEvt) begin
          causeSet[`DEHSC_CAUSE_HALTED] = 1'b1;
        end else if (extEvt) begin
          causeSet[`DEHSC_CAUSE_EXT] = 1'b1;
        end else if (watchEvt) begin
          causeSet[`DEHSC_CAUSE_WATCH] = 1'b1;
        end else begin
          takeHalt = 1'b0;
        end
      end else if (bkptEvt) begin
        // Disabled: only the breakpoint instruction acts
        // Comparator matches are ignored while disabled
        causeSet[`DEHSC_CAUSE_BREAKPOINT_CAUSE_FLAG] = 1'b1;
        raiseHf = ~inNmiOrHardFault;
        raiseLock = inNmiOrHardFault;
      end
    end
  end

  // Debug state machine and control register
  always @* begin
    state_d = state_q;
    stepped_d = stepped_q;
    case (state_q)
      ST_RUN: begin
        // A taken event halts at the next edge
        if (takeHalt) begin
          state_d = ST_HALT;
        end
      end
      ST_HALT: begin
        if (ctrlWr & dbgEn_q & ~hwdata[`DEHSC_CTRL_HALT]) begin
          // Step leaves and comes back; plain release resumes
          // The releasing write must carry the step bit itself
          if (hwdata[`DEHSC_CTRL_STEP]) begin
            state_d = ST_STEP;
          end else begin
            state_d = ST_RUN;
          end
          // Step progress restarts on every release
          stepped_d = 1'b0;
        end
      end
      ST_STEP: begin
        // First boundary runs the stepped instruction; the next one halts
        // After an exception entry or tail chain the core reports its next
        // boundary at the handler's first instruction, so only one stacking
        if (takeHalt) begin
          state_d = ST_HALT;
        end else if (boundary) begin
          stepped_d = 1'b1;
        end
      end
      default: state_d = ST_RUN;
    endcase
    // With halting debug off the control bits have no effect
    if (~dbgEn_q) begin
      state_d = ST_RUN;
    end
  end

  // Control and state flops; local reset restarts the core side only
  // Power-on reset clears every bit held here
  always @(posedge mclk) begin
    if (rst) begin
      state_q <= ST_RUN;
      stepped_q <= 1'b0;
      dbgEn_q <= 1'b0;
      haltReq_q <= 1'b0;
      stepReq_q <= 1'b0;
      maskInts_q <= 1'b0;
      catchRst_q <= 1'b0;
      catchHf_q <= 1'b0;
      lockup_q <= 1'b0;
      hard_fault_exception_q <= 1'b0;
      suppress_q <= 1'b0;
    end else begin
      state_q <= localRst ? ST_RUN : state_d;
      stepped_q <= localRst ? 1'b0 : stepped_d;
      // Lockup stays until either reset
      lockup_q <= ~localRst & (lockup_q | raiseLock);
      // Escalation and suppression are one-cycle pulses
      hard_fault_exception_q <= raiseHf;
      suppress_q <= takeSync;
      // Control bits ignore the local reset
      if (ctrlWr) begin
        dbgEn_q <= hwdata[`DEHSC_CTRL_DBGEN];
        haltReq_q <= hwdata[`DEHSC_CTRL_HALT];
        stepReq_q <= hwdata[`DEHSC_CTRL_STEP];
        maskInts_q <= hwdata[`DEHSC_CTRL_MASK];
      end
      // Entering Debug state raises the halt request bit too, so a read
      // after a new event shows both halt bits set
      if (takeHalt) begin
        haltReq_q <= 1'b1;
      end
      // Catch enables
      if (monWr) begin
        catchRst_q <= hwdata[`DEHSC_MON_CATCH_RST];
        catchHf_q <= hwdata[`DEHSC_MON_CATCH_HF];
      end
    end
  end

  // Sticky cause flags
  // Kept in their own module, which sees only the power-on reset
  dehsc_cause_reg u_dehsc_cause_reg (
    .mclk(mclk),
    .rst(rst),
    .setBits(causeSet),
    .clrWe(causeClr),
    .clrBits(hwdata[`DEHSC_CAUSE_W-1:0]),
    .causeBits(causeBits)
  );

  // Core-facing outputs
  assign halted = isHalted;
  // Run is refused while halted or locked up
  assign runEnable = ~isHalted & ~lockup_q;
  assign hardFaultReq = hard_fault_exception_q;
  assign lockup = lockup_q;
  assign suppressSync = suppress_q;
  // The three maskable sources share one gate
  assign blockPendSv = maskActive;
  assign blockSysTick = maskActive;
  assign blockExtIrq = maskActive;
endmodule
`default_nettype wire
